// File: inc/dce_pkg.sv
package dce_pkg;
	localparam logic [3:0]  ADDR_CON   = 4'h0;
	localparam logic [3:0]  ADDR_ECON  = 4'h4;
	localparam logic [3:0]  ADDR_INT   = 4'h8;
	localparam logic [3:0]  ADDR_LINK  = 4'hC;
	localparam int          CON_PRI_LO = 0;
	localparam int          CON_EDET   = 2;
	localparam int          CON_AEN    = 4;
	localparam int          CON_CHN    = 5;
	localparam int          CON_AED    = 6;
	localparam int          CON_EN     = 7;
	localparam int          CON_CHNS   = 8;
	localparam int          CON_BUSY   = 15;
	localparam int          EC_ABT_EN  = 3;
	localparam int          EC_STA_EN  = 4;
	localparam int          EC_PAT_EN  = 5;
	localparam int          EC_ABORT   = 6;
	localparam int          EC_FORCE   = 7;
	localparam int          EC_SIRQ_LO = 8;
	localparam int          EC_AIRQ_LO = 16;
	localparam logic [31:0] CON_WMASK  = 32'h000001F3;
	localparam logic [31:0] ECON_WMASK = 32'h00FFFF38;
	localparam logic [31:0] INT_WMASK  = 32'h00FF0000;
	localparam logic [31:0] ECON_RST   = 32'h00FFFF00;
	localparam int          IE_SHIFT   = 16;
	localparam int          F_ERR      = 0;
	localparam int          F_ABORT    = 1;
	localparam int          F_CELL     = 2;
	localparam int          F_BLOCK    = 3;
	localparam int          F_DHALF    = 4;
	localparam int          F_DDONE    = 5;
	localparam int          F_SHALF    = 6;
	localparam int          F_SDONE    = 7;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_STOP = 2'b11
	} dce_state_type;
endpackage : dce_pkg

// File: inc/dce_event_if.sv
`timescale 1ns/100ps
interface dce_event_if;
	logic [7:0] irqNum;
	logic       irqValid;
	logic [7:0] startNum;
	logic [7:0] abortNum;
	logic       startEn;
	logic       abortEn;
	logic       startHit;
	logic       abortHit;
	modport match (input irqNum, irqValid, startNum, abortNum, startEn, abortEn,
		output startHit, abortHit);
	modport ctrl (output irqNum, irqValid, startNum, abortNum, startEn, abortEn,
		input startHit, abortHit);
endinterface : dce_event_if

// File: rtl/dce_irq_match.sv
`timescale 1ns/100ps
module dce_irq_match (
	dce_event_if.match ev    // interrupt number compare
);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] b, input logic en,
		input logic v);
		hit = v && en && (a == b);
	endfunction : hit

	assign ev.startHit = hit(ev.irqNum, ev.startNum, ev.startEn, ev.irqValid); // RULE8 RULE12
	assign ev.abortHit = hit(ev.irqNum, ev.abortNum, ev.abortEn, ev.irqValid); // RULE7 RULE13
endmodule : dce_irq_match

// File: rtl/dce_channel.sv
// How it works
// RULE1: a neighbour's completion enables this channel only when chain_permit is set.
// RULE2: auto_reenable keeps channel on after block done; otherwise channel_on clears.
// RULE3: event_seen at control bit 2 is read-only, set once a trigger is seen.
// RULE4: two-bit priority in control bits 1-0, 11 highest, 00 lowest.
// RULE5: chain direction select matters only while chain_permit is set.
// RULE6: clearing channel_on suspends only after the current transaction ends.
// RULE7: abort number in bits 23-16 picks the interrupt that aborts, sets abort_flag.
// RULE8: start number in bits 15-8 picks the interrupt that starts a transfer.
// RULE9: writing force_start bit 7 begins a transfer at once; reads zero.
// RULE10: writing force_abort bit 6 aborts the transfer; reads zero.
// RULE11: pattern_abort_enable makes a pattern match abort and clear channel_on.
// RULE12: start_irq_enable gates the start interrupt match.
// RULE13: abort_irq_enable gates the abort interrupt match.
// RULE14: event control bits 2-0 and 31-24 read zero and ignore writes.
// RULE15: busy reads one while channel active or enabled.
// RULE16: events_when_off lets start/abort register while channel disabled.
// RULE17: block_done_flag sets on block complete or pattern match.
// RULE18: address_error_flag sets on invalid source or destination address.
// RULE19: interrupt high when any flag is set with its enable sixteen bits above.
`timescale 1ns/100ps
module dce_channel (
	input  wire logic        mclk,        // system clock
	input  wire logic        nrst,        // async reset, active low
	input  wire logic        psel,        // apb select
	input  wire logic        penable,     // apb access phase
	input  wire logic        pwrite,      // apb direction
	input  wire logic [3:0]  paddr,       // apb byte address
	input  wire logic [31:0] pwdata,      // apb write data
	output logic      [31:0] prdata,      // apb read data
	output logic             pready,      // apb ready
	output logic             pslverr,     // apb error
	input  wire logic [7:0]  irqNum,      // interrupt number on event bus
	input  wire logic        irqValid,    // interrupt number valid
	input  wire logic        chainLower,  // lower-priority neighbour finished
	input  wire logic        chainHigher, // higher-priority neighbour finished
	input  wire logic        xferDone,    // current transaction finished
	input  wire logic        cellDone,    // cell transfer complete
	input  wire logic        blockDone,   // larger of sizes moved
	input  wire logic        patternHit,  // pattern match seen
	input  wire logic        srcHalf,     // source pointer midpoint
	input  wire logic        srcDone,     // source pointer end
	input  wire logic        dstHalf,     // destination pointer midpoint
	input  wire logic        dstDone,     // destination pointer end
	input  wire logic        addrError,   // invalid source or destination
	output logic             startReq,    // pulse: begin a transfer
	output logic             abortReq,    // pulse: abort the transfer
	output logic             chanActive,  // channel running a transaction
	output logic [1:0]       chanPri,     // channel priority
	output logic             chanIrq      // channel interrupt, level
);
	typedef struct packed {
		dce_pkg::dce_state_type st;
		logic [31:0] con;
		logic [31:0] econ;
		logic [31:0] intr;
		logic [31:0] rdata;
		logic        ready;
		logic        err;
		logic        start;
		logic        abort;
		logic        irq;
		logic [1:0]  pri;
		logic        active;
	} dce_regs_type;

	dce_regs_type r;
	dce_regs_type next_r;
	dce_event_if  ev ();

	assign ev.irqNum   = irqNum;
	assign ev.irqValid = irqValid;
	assign ev.startNum = r.econ[dce_pkg::EC_SIRQ_LO +: 8];
	assign ev.abortNum = r.econ[dce_pkg::EC_AIRQ_LO +: 8];
	assign ev.startEn  = r.econ[dce_pkg::EC_STA_EN];
	assign ev.abortEn  = r.econ[dce_pkg::EC_ABT_EN];

	dce_irq_match u_match (
		.ev(ev.match)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [31:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction : merge

	logic setup;
	logic wr;
	logic en;
	logic evOk;
	logic chainHit;
	logic fStart;
	logic fAbort;
	logic doStart;
	logic doAbort;
	logic patAbort;
	logic [7:0] evFlags;

	always_comb begin
		next_r = r;
		setup = psel && !penable;
		wr = psel && penable && pwrite && r.ready;
		en = r.con[dce_pkg::CON_EN];
		evOk = en || r.con[dce_pkg::CON_AED]; // RULE16
		// direction only looked at under chain_permit
		chainHit = r.con[dce_pkg::CON_CHN] && (r.con[dce_pkg::CON_CHNS] ? chainLower
			: chainHigher); // RULE1 RULE5
		fStart = wr && (paddr == dce_pkg::ADDR_ECON) && pwdata[dce_pkg::EC_FORCE]; // RULE9
		fAbort = wr && (paddr == dce_pkg::ADDR_ECON) && pwdata[dce_pkg::EC_ABORT]; // RULE10
		patAbort = patternHit && r.econ[dce_pkg::EC_PAT_EN]; // RULE11
		doAbort = fAbort || patAbort || (ev.abortHit && evOk); // RULE7 RULE13
		doStart = !doAbort && (fStart || (ev.startHit && evOk)); // RULE8 RULE12
		next_r.start = doStart;
		next_r.abort = doAbort;
		next_r.ready = setup;
		next_r.err = 1'b0;
		// apb writes; hardware events below take priority
		if (wr) begin
			if (paddr == dce_pkg::ADDR_CON) begin
				next_r.con = merge(r.con, pwdata, dce_pkg::CON_WMASK);
			end else if (paddr == dce_pkg::ADDR_ECON) begin
				next_r.econ = merge(r.econ, pwdata, dce_pkg::ECON_WMASK); // RULE14
			end else if (paddr == dce_pkg::ADDR_INT) begin
				next_r.intr = merge(r.intr, pwdata, dce_pkg::INT_WMASK);
				next_r.intr[7:0] = r.intr[7:0] & ~pwdata[7:0];
			end
		end
		if (chainHit) begin
			next_r.con[dce_pkg::CON_EN] = 1'b1; // RULE1
		end
		if (doStart || doAbort) begin
			next_r.con[dce_pkg::CON_EDET] = 1'b1; // RULE3
		end
		if (blockDone && !r.con[dce_pkg::CON_AEN]) begin
			next_r.con[dce_pkg::CON_EN] = 1'b0; // RULE2
		end
		if (patAbort) begin
			next_r.con[dce_pkg::CON_EN] = 1'b0; // RULE11
		end
		// suspend waits for transaction end
		case (r.st)
			dce_pkg::ST_IDLE: begin
				if (doStart && (en || chainHit)) begin
					next_r.st = dce_pkg::ST_RUN;
				end
			end
			dce_pkg::ST_RUN: begin
				if (doAbort || blockDone) begin
					next_r.st = dce_pkg::ST_IDLE;
				end else if (!next_r.con[dce_pkg::CON_EN]) begin
					next_r.st = dce_pkg::ST_STOP; // RULE6
				end
			end
			dce_pkg::ST_STOP: begin
				if (xferDone || doAbort) begin
					next_r.st = dce_pkg::ST_IDLE; // RULE6
				end
			end
			default: begin
				next_r.st = dce_pkg::ST_IDLE;
			end
		endcase
		next_r.active = (next_r.st != dce_pkg::ST_IDLE);
		next_r.con[dce_pkg::CON_BUSY] = next_r.active || next_r.con[dce_pkg::CON_EN]; // RULE15
		evFlags = '0;
		evFlags[dce_pkg::F_ERR]   = addrError; // RULE18
		evFlags[dce_pkg::F_ABORT] = doAbort; // RULE7
		evFlags[dce_pkg::F_CELL]  = cellDone;
		evFlags[dce_pkg::F_BLOCK] = blockDone || patternHit; // RULE17
		evFlags[dce_pkg::F_DHALF] = dstHalf;
		evFlags[dce_pkg::F_DDONE] = dstDone;
		evFlags[dce_pkg::F_SHALF] = srcHalf;
		evFlags[dce_pkg::F_SDONE] = srcDone;
		// set wins over a write-one clear
		next_r.intr[7:0] = next_r.intr[7:0] | evFlags;
		next_r.irq = |(next_r.intr[7:0] & next_r.intr[dce_pkg::IE_SHIFT +: 8]); // RULE19
		next_r.pri = next_r.con[dce_pkg::CON_PRI_LO +: 2]; // RULE4
		next_r.rdata = '0;
		if (setup && !pwrite) begin
			if (paddr == dce_pkg::ADDR_CON) begin
				next_r.rdata = r.con;
			end else if (paddr == dce_pkg::ADDR_ECON) begin
				next_r.rdata = r.econ & dce_pkg::ECON_WMASK; // RULE9 RULE10 RULE14
			end else if (paddr == dce_pkg::ADDR_INT) begin
				next_r.rdata = r.intr;
			end else begin
				next_r.rdata = '0;
			end
		end
		if (setup && (paddr[1:0] != 2'h0 || paddr == dce_pkg::ADDR_LINK)) begin
			next_r.err = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			r <= '{st: dce_pkg::ST_IDLE, con: '0, econ: dce_pkg::ECON_RST, intr: '0,
				rdata: '0, ready: 1'b0, err: 1'b0, start: 1'b0, abort: 1'b0, irq: 1'b0,
				pri: 2'h0, active: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign prdata     = r.rdata;
	assign pready     = r.ready;
	assign pslverr    = r.err;
	assign startReq   = r.start;
	assign abortReq   = r.abort;
	assign chanActive = r.active;
	assign chanPri    = r.pri;
	assign chanIrq    = r.irq;
endmodule : dce_channel

// File: sim/dce_channel_props.sv
`timescale 1ns/100ps
module dce_channel_props (
	input wire logic        mclk,       // clock
	input wire logic        nrst,       // reset
	input wire logic        psel,       // select
	input wire logic        penable,    // access
	input wire logic        pwrite,     // write
	input wire logic [3:0]  paddr,      // address
	input wire logic [31:0] pwdata,     // write data
	input wire logic [31:0] prdata,     // read data
	input wire logic        pready,     // ready
	input wire logic        irqValid,   // event strobe
	input wire logic        patternHit, // pattern match
	input wire logic        abortReq,   // abort pulse
	input wire logic [1:0]  chanPri,    // priority
	input wire logic        chanIrq     // interrupt
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire acc = psel && penable && pready;
	wire wrC = acc && pwrite && paddr == 4'h0;
	wire rdC = acc && !pwrite && paddr == 4'h0;
	wire wrE = acc && pwrite && paddr == 4'h4;
	wire rdE = acc && !pwrite && paddr == 4'h4;
	a_ready_next: assert property (psel && !penable |=> pready) else $error("ready late");
	a_ready_only: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
	a_pri_write: assert property (wrC |=> chanPri == $past(pwdata[1:0]))
		else $error("priority not taken");
	a_pri_hold: assert property (!$stable(chanPri) |-> $past(wrC))
		else $error("priority moved");
	a_econ_zero: assert property (rdE |-> (prdata & 32'hFF0000C7) == 32'h0)
		else $error("event control bits not zero");
	a_busy_on: assert property (rdC && prdata[7] |-> prdata[15])
		else $error("busy low while on");
	a_abort_why: assert property (abortReq |-> $past(irqValid || patternHit || wrE && pwdata[6]))
		else $error("abort without cause");
	a_irq_drop: assert property ($fell(chanIrq) |-> $past(acc && pwrite))
		else $error("interrupt dropped alone");
	c_abort: cover property (abortReq);
	c_irq: cover property (chanIrq);
	c_busy: cover property (rdC && prdata[15]);
endmodule : dce_channel_props

// File: sim/dce_far_model.sv
`timescale 1ns/100ps
module dce_far_model (
	input  wire logic        mclk,     // clock
	output logic      [7:0]  irqNum,   // event number
	output logic             irqValid, // event strobe
	output logic      [10:0] ev        // done, error and chain pulses
);
	initial {irqNum, irqValid, ev} = 20'h0;
	task automatic drive(input logic [8:0] n, input logic [10:0] p);
		@(posedge mclk);
		{irqValid, irqNum, ev} <= {n, p};
		@(posedge mclk);
		// stale number inverted so nothing leans on a held bus
		{irqValid, irqNum, ev} <= {1'b0, ~n[7:0], 11'h0};
	endtask : drive
endmodule : dce_far_model

// File: sim/dce_channel_bench.sv
`timescale 1ns/100ps
module dce_channel_bench;
	logic        mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [3:0]  paddr = 4'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready, pslverr, irqValid, startReq, abortReq, chanActive, chanIrq, err;
	logic        chainLower, chainHigher, xferDone, cellDone, blockDone, patternHit;
	logic        srcHalf, srcDone, dstHalf, dstDone, addrError;
	logic [7:0]  irqNum;
	logic [1:0]  chanPri;
	logic [10:0] ev;
	int          miscompares = 0, cmpCount = 0;
	logic [31:0] nEv = 32'h0, b = 32'h0;
	assign {addrError, dstDone, dstHalf, srcDone, srcHalf, patternHit, blockDone, cellDone,
		xferDone, chainHigher, chainLower} = ev;
	always #2 mclk = ~mclk;
	// starts in the low byte, aborts above it
	// four-state sum so an unknown pulse poisons the count
	always @(posedge mclk) begin
		if (nrst) begin
			nEv <= nEv + {31'h0, startReq} + {23'h0, abortReq, 8'h0};
		end
	end
	dce_channel u_dce_channel (.*);
	dce_far_model u_dce_far_model (.*);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmpCount++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h, want %h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(r & m, e);
	endtask : rd
	task automatic cnt(input logic [31:0] e);
		repeat (2) @(posedge mclk);
		chk(nEv - b, e);
		b = nEv;
	endtask : cnt
	task automatic t_regs;
		rd(4'h0, 32'hFFFFFFFF, 32'h0);
		rd(4'h4, 32'hFFFFFFFF, 32'h00FFFF00);
		rd(4'h8, 32'hFFFFFFFF, 32'h0);
		rd(4'hC, 32'hFFFFFFFF, 32'h0);
		chk(32'(err), 32'h1);
		apb(1'b1, 4'h4, 32'hFFFFFF3F);
		rd(4'h4, 32'hFFFFFFFF, 32'h00FFFF38);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 4'h0, 32'(i));
			@(posedge mclk);
			chk(32'(chanPri), 32'(i));
		end
		$display("register test done");
	endtask : t_regs
	task automatic t_irq;
		apb(1'b1, 4'h0, 32'h80);
		apb(1'b1, 4'h4, 32'h00222118);
		u_dce_far_model.drive(9'h120, 11'h0);
		u_dce_far_model.drive(9'h121, 11'h0);
		cnt(32'h1);
		rd(4'h0, 32'h8084, 32'h8084);
		u_dce_far_model.drive(9'h122, 11'h0);
		cnt(32'h100);
		rd(4'h8, 32'hFFFFFFFF, 32'h2);
		apb(1'b1, 4'h8, 32'h00020000);
		@(posedge mclk);
		chk(32'(chanIrq), 32'h1);
		apb(1'b1, 4'h8, 32'h00020002);
		@(posedge mclk);
		chk(32'(chanIrq), 32'h0);
		apb(1'b1, 4'h0, 32'h80);
		apb(1'b1, 4'h4, 32'h00222100);
		u_dce_far_model.drive(9'h121, 11'h0);
		u_dce_far_model.drive(9'h122, 11'h0);
		cnt(32'h0);
		$display("interrupt number test done");
	endtask : t_irq
	task automatic t_flow;
		apb(1'b1, 4'h0, 32'h80);
		u_dce_far_model.drive(9'h0, 11'h010);
		rd(4'h0, 32'h80, 32'h0);
		apb(1'b1, 4'h0, 32'h90);
		u_dce_far_model.drive(9'h0, 11'h410);
		rd(4'h0, 32'h90, 32'h90);
		rd(4'h8, 32'h9, 32'h9);
		apb(1'b1, 4'h0, 32'h0);
		u_dce_far_model.drive(9'h0, 11'h004);
		rd(4'h0, 32'h8000, 32'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 4'h0, {23'h0, i[1], 2'b00, i != 3, 5'h00});
			u_dce_far_model.drive(9'h0, i == 1 ? 11'h002 : 11'h001);
			rd(4'h0, 32'h80, i == 1 || i == 2 ? 32'h80 : 32'h0);
		end
		$display("flow test done");
	endtask : t_flow
	task automatic t_force;
		b = nEv;
		apb(1'b1, 4'h0, 32'h80);
		apb(1'b1, 4'h4, 32'h00222180);
		apb(1'b1, 4'h4, 32'h00222140);
		cnt(32'h101);
		rd(4'h4, 32'hFFFFFFFF, 32'h00222100);
		apb(1'b1, 4'h0, 32'h80);
		apb(1'b1, 4'h4, 32'h00222120);
		u_dce_far_model.drive(9'h0, 11'h020);
		cnt(32'h100);
		rd(4'h0, 32'h80, 32'h0);
		$display("force test done");
	endtask : t_force
	task automatic t_modes;
		apb(1'b1, 4'h0, 32'h0);
		apb(1'b1, 4'h4, 32'h00222110);
		u_dce_far_model.drive(9'h121, 11'h0);
		cnt(32'h0);
		apb(1'b1, 4'h0, 32'h40);
		u_dce_far_model.drive(9'h121, 11'h0);
		cnt(32'h1);
		apb(1'b1, 4'h0, 32'h80);
		// start and pattern match together, pattern abort off
		u_dce_far_model.drive(9'h121, 11'h020);
		cnt(32'h1);
		rd(4'h0, 32'h8080, 32'h8080);
		chk(32'(chanActive), 32'h1);
		apb(1'b1, 4'h0, 32'h0);
		// software polls busy: still set until the transaction ends
		rd(4'h0, 32'h8080, 32'h8000);
		chk(32'(chanActive), 32'h1);
		u_dce_far_model.drive(9'h0, 11'h004);
		rd(4'h0, 32'h8000, 32'h0);
		chk(32'(chanActive), 32'h0);
		$display("mode test done");
	endtask : t_modes
	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		t_regs;
		t_irq;
		t_flow;
		t_force;
		t_modes;
		wrap_up;
	end
	initial begin
		#20000;
		miscompares++;
		wrap_up;
	end
endmodule : dce_channel_bench
bind dce_channel dce_channel_props u_dce_channel_props (.*);
